// ==== verilog/cmoh_top.sv ====
// Message object handler: interface registers, object RAM, receive scan, transmit ordering.
// Assumes software on Avalon-MM and a CAN protocol engine on plain ports, one clock.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cmoh_top #(
    parameter int N = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Receive side of the protocol engine
    input wire logic rx_header_valid,
    input wire logic [28:0] rx_id,
    input wire logic rx_xtd,
    input wire logic rx_remote,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_payload,
    // Transmit side of the protocol engine
    input wire logic tx_ready,
    input wire logic tx_ok,
    output logic tx_start,
    output logic [28:0] tx_id,
    output logic tx_xtd,
    output logic tx_remote,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_payload,
    // Status
    output logic [4:0] interrupt_identification_register
);
    // Object RAM
    logic [31:0] obj_arb [N];
    logic [31:0] obj_msk [N];
    logic [31:0] obj_ctl [N];
    logic [63:0] obj_data [N];
    logic [31:0] next_arb;
    logic [31:0] next_msk;
    logic [31:0] next_ctl;
    logic [63:0] next_data;
    logic [4:0] wr_idx;
    logic wr_en;
    // Interface registers
    logic [31:0] cmd_mask, next_cmd_mask;
    logic [31:0] if_arb, next_if_arb;
    logic [31:0] if_msk, next_if_msk;
    logic [31:0] if_ctl, next_if_ctl;
    logic [63:0] if_data, next_if_data;
    logic [4:0] cmd_obj, next_cmd_obj;
    logic [4:0] int_id, next_int_id;
    logic [4:0] tx_obj, next_tx_obj;
    logic tx_busy, next_tx_busy;
    logic tx_start_q, next_tx_start;
    logic rx_pend, next_rx_pend;
    logic ok_pend, next_ok_pend;
    cmoh_pkg::cmoh_state_t state, next_state;
    // Frame header capture
    logic [28:0] cap_id, next_cap_id;
    logic cap_xtd, next_cap_xtd;
    logic cap_remote, next_cap_remote;
    logic [3:0] cap_dlc, next_cap_dlc;
    logic [63:0] cap_data, next_cap_data;
    // Scan
    logic [N*32-1:0] arb_flat, msk_flat;
    logic [N-1:0] use_acceptance_mask_v, txrq_v;
    logic hit;
    logic [4:0] hit_idx;
    logic tx_hit;
    logic [4:0] tx_pick;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flat
            assign arb_flat[g*32 +: 32] = obj_arb[g];
            assign msk_flat[g*32 +: 32] = obj_msk[g];
            assign use_acceptance_mask_v[g] = obj_ctl[g][cmoh_pkg::CTL_USE_ACCEPTANCE_MASK];
            assign txrq_v[g] = obj_ctl[g][cmoh_pkg::CTL_TRANSMIT_REQUEST] && obj_arb[g][cmoh_pkg::ARB_VALID];
        end
    endgenerate

    cmoh_scan #(.N(N)) u_scan (
        .arb_flat(arb_flat),
        .msk_flat(msk_flat),
        .use_acceptance_mask(use_acceptance_mask_v),
        .rx_id(cap_id),
        .rx_xtd(cap_xtd),
        .rx_remote(cap_remote),
        .hit(hit),
        .hit_idx(hit_idx)
    );

    // Lowest pending object number wins, identifier plays no part
    always_comb begin
        tx_hit = 1'b0;
        tx_pick = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (txrq_v[i]) begin
                tx_hit = 1'b1;
                tx_pick = 5'(i);
            end
        end
    end

    function automatic logic [4:0] obj_of(input logic [31:0] w);
        obj_of = w[4:0] - 5'h01;
    endfunction : obj_of

    logic sel_low, sel_high, cm_wr;
    assign cm_wr = cmd_mask[cmoh_pkg::CM_WRITE_NOT_READ];
    assign sel_low = cmd_mask[cmoh_pkg::CM_PAYLOAD_LOW];
    assign sel_high = cmd_mask[cmoh_pkg::CM_PAYLOAD_HIGH];
    // Bus access is answered only in idle so transfers never collide
    assign waitrequest = (read || write) && (state != cmoh_pkg::CMOH_IDLE || rx_pend);

    always_comb begin
        next_state = state;
        next_cmd_mask = cmd_mask;
        next_if_arb = if_arb;
        next_if_msk = if_msk;
        next_if_ctl = if_ctl;
        next_if_data = if_data;
        next_cmd_obj = cmd_obj;
        next_int_id = int_id;
        next_tx_obj = tx_obj;
        next_tx_busy = tx_busy;
        next_tx_start = 1'b0;
        next_rx_pend = rx_pend;
        next_ok_pend = ok_pend || (tx_ok && tx_busy);
        next_cap_id = cap_id;
        next_cap_xtd = cap_xtd;
        next_cap_remote = cap_remote;
        next_cap_dlc = cap_dlc;
        next_cap_data = cap_data;
        wr_en = 1'b0;
        wr_idx = cmd_obj;
        next_arb = obj_arb[cmd_obj];
        next_msk = obj_msk[cmd_obj];
        next_ctl = obj_ctl[cmd_obj];
        next_data = obj_data[cmd_obj];
        if (rx_header_valid) begin
            next_rx_pend = 1'b1;
            next_cap_id = rx_id;
            next_cap_xtd = rx_xtd;
            next_cap_remote = rx_remote;
            next_cap_dlc = rx_dlc;
            next_cap_data = rx_payload;
        end
        case (state)
            cmoh_pkg::CMOH_IDLE: begin
                if (rx_pend) begin
                    next_state = cmoh_pkg::CMOH_RX_SCAN;
                end else if (write && !waitrequest) begin
                    if (address == cmoh_pkg::OFF_CMD_MASK) begin
                        next_cmd_mask = writedata;
                    end else if (address == cmoh_pkg::OFF_CMD_REQ) begin
                        next_cmd_obj = obj_of(writedata);
                        next_state = cmoh_pkg::CMOH_XFER;
                    end else if (address == cmoh_pkg::OFF_MASK) begin
                        next_if_msk = writedata;
                    end else if (address == cmoh_pkg::OFF_ARB) begin
                        next_if_arb = writedata;
                    end else if (address == cmoh_pkg::OFF_CTL) begin
                        next_if_ctl = writedata;
                    end else if (address == cmoh_pkg::OFF_DATA_LO) begin
                        next_if_data[31:0] = writedata;
                    end else if (address == cmoh_pkg::OFF_DATA_HI) begin
                        next_if_data[63:32] = writedata;
                    end
                end else if (tx_ready && !tx_busy && tx_hit) begin
                    next_tx_obj = tx_pick;
                    next_state = cmoh_pkg::CMOH_TX_LOAD;
                end else if (ok_pend) begin
                    next_state = cmoh_pkg::CMOH_TX_DONE;
                end
            end
            cmoh_pkg::CMOH_XFER: begin
                next_state = cmoh_pkg::CMOH_IDLE;
                if (cm_wr) begin
                    wr_en = 1'b1;
                    // Only selected parts change; valid and request need no clearing
                    if (cmd_mask[cmoh_pkg::CM_ARB]) next_arb = if_arb;
                    if (cmd_mask[cmoh_pkg::CM_MASK]) next_msk = if_msk;
                    if (cmd_mask[cmoh_pkg::CM_CONTROL]) next_ctl = if_ctl;
                    if (sel_low) next_data[31:0] = if_data[31:0];
                    if (sel_high) next_data[63:32] = if_data[63:32];
                    if (cmd_mask[cmoh_pkg::CM_TXRQ_NEW_DATA_FLAG]) begin
                        next_ctl[cmoh_pkg::CTL_TRANSMIT_REQUEST] = 1'b1;
                        next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG] = 1'b1;
                    end
                    if (cmd_mask[cmoh_pkg::CM_CLR_INT]) next_ctl[cmoh_pkg::CTL_INTERRUPT_PENDING] = 1'b0;
                end else begin
                    next_if_arb = obj_arb[cmd_obj];
                    next_if_msk = obj_msk[cmd_obj];
                    next_if_ctl = obj_ctl[cmd_obj];
                    next_if_data = obj_data[cmd_obj];
                    wr_en = 1'b1;
                    if (cmd_mask[cmoh_pkg::CM_TXRQ_NEW_DATA_FLAG]) next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG] = 1'b0;
                    if (cmd_mask[cmoh_pkg::CM_CLR_INT]) next_ctl[cmoh_pkg::CTL_INTERRUPT_PENDING] = 1'b0;
                end
                if (cmd_mask[cmoh_pkg::CM_CLR_INT] && int_id == cmd_obj + 5'h01) next_int_id = 5'h00;
            end
            cmoh_pkg::CMOH_RX_SCAN: begin
                next_rx_pend = rx_header_valid;
                next_state = hit ? cmoh_pkg::CMOH_RX_STORE : cmoh_pkg::CMOH_IDLE;
            end
            cmoh_pkg::CMOH_RX_STORE: begin
                next_state = cmoh_pkg::CMOH_IDLE;
                wr_idx = hit_idx;
                next_arb = obj_arb[hit_idx];
                next_msk = obj_msk[hit_idx];
                next_ctl = obj_ctl[hit_idx];
                next_data = obj_data[hit_idx];
                if (!cap_remote) begin
                    wr_en = 1'b1;
                    next_data = cap_data;
                    next_arb[28:0] = cap_id;
                    next_arb[cmoh_pkg::ARB_XTD] = cap_xtd;
                    next_ctl[3:0] = cap_dlc;
                    next_ctl[cmoh_pkg::CTL_TRANSMIT_REQUEST] = 1'b0;
                    if (next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG]) next_ctl[cmoh_pkg::CTL_MESSAGE_LOST_FLAG] = 1'b1;
                    next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG] = 1'b1;
                    if (next_ctl[cmoh_pkg::CTL_RECEIVE_INTERRUPT_ENABLE]) begin
                        next_ctl[cmoh_pkg::CTL_INTERRUPT_PENDING] = 1'b1;
                        next_int_id = hit_idx + 5'h01;
                    end
                end else if (next_ctl[cmoh_pkg::CTL_REMOTE_ENABLE]) begin
                    wr_en = 1'b1;
                    next_ctl[cmoh_pkg::CTL_TRANSMIT_REQUEST] = 1'b1;
                end else if (next_ctl[cmoh_pkg::CTL_USE_ACCEPTANCE_MASK]) begin
                    wr_en = 1'b1;
                    next_ctl[cmoh_pkg::CTL_TRANSMIT_REQUEST] = 1'b0;
                    next_arb[28:0] = cap_id;
                    next_arb[cmoh_pkg::ARB_XTD] = cap_xtd;
                    next_ctl[3:0] = cap_dlc;
                    next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG] = 1'b1;
                end
                // Otherwise remote frame is dropped without trace
            end
            cmoh_pkg::CMOH_TX_LOAD: begin
                next_state = cmoh_pkg::CMOH_IDLE;
                next_tx_busy = 1'b1;
                next_tx_start = 1'b1;
                wr_en = 1'b1;
                wr_idx = tx_obj;
                next_arb = obj_arb[tx_obj];
                next_msk = obj_msk[tx_obj];
                next_ctl = obj_ctl[tx_obj];
                next_data = obj_data[tx_obj];
                next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG] = 1'b0;
            end
            cmoh_pkg::CMOH_TX_DONE: begin
                next_state = cmoh_pkg::CMOH_IDLE;
                next_tx_busy = 1'b0;
                next_ok_pend = 1'b0;
                wr_en = 1'b1;
                wr_idx = tx_obj;
                next_arb = obj_arb[tx_obj];
                next_msk = obj_msk[tx_obj];
                next_ctl = obj_ctl[tx_obj];
                next_data = obj_data[tx_obj];
                if (!next_ctl[cmoh_pkg::CTL_NEW_DATA_FLAG]) next_ctl[cmoh_pkg::CTL_TRANSMIT_REQUEST] = 1'b0;
                if (next_ctl[cmoh_pkg::CTL_TXIE]) begin
                    next_ctl[cmoh_pkg::CTL_INTERRUPT_PENDING] = 1'b1;
                    next_int_id = tx_obj + 5'h01;
                end
            end
            default: next_state = cmoh_pkg::CMOH_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= cmoh_pkg::CMOH_IDLE;
            cmd_mask <= cmoh_pkg::RESET_WORD;
            if_arb <= cmoh_pkg::RESET_WORD;
            if_msk <= cmoh_pkg::RESET_WORD;
            if_ctl <= cmoh_pkg::RESET_WORD;
            if_data <= 64'h0;
            cmd_obj <= 5'h00;
            int_id <= 5'h00;
            tx_obj <= 5'h00;
            tx_busy <= 1'b0;
            tx_start_q <= 1'b0;
            rx_pend <= 1'b0;
            ok_pend <= 1'b0;
            cap_id <= 29'h0;
            cap_xtd <= 1'b0;
            cap_remote <= 1'b0;
            cap_dlc <= 4'h0;
            cap_data <= 64'h0;
            for (int i = 0; i < N; i++) begin
                obj_arb[i] <= cmoh_pkg::RESET_WORD;
                obj_msk[i] <= cmoh_pkg::RESET_WORD;
                obj_ctl[i] <= cmoh_pkg::RESET_WORD;
                obj_data[i] <= 64'h0;
            end
        end else begin
            state <= next_state;
            cmd_mask <= next_cmd_mask;
            if_arb <= next_if_arb;
            if_msk <= next_if_msk;
            if_ctl <= next_if_ctl;
            if_data <= next_if_data;
            cmd_obj <= next_cmd_obj;
            int_id <= next_int_id;
            tx_obj <= next_tx_obj;
            tx_busy <= next_tx_busy;
            tx_start_q <= next_tx_start;
            rx_pend <= next_rx_pend;
            ok_pend <= next_ok_pend;
            cap_id <= next_cap_id;
            cap_xtd <= next_cap_xtd;
            cap_remote <= next_cap_remote;
            cap_dlc <= next_cap_dlc;
            cap_data <= next_cap_data;
            if (wr_en) begin
                obj_arb[wr_idx] <= next_arb;
                obj_msk[wr_idx] <= next_msk;
                obj_ctl[wr_idx] <= next_ctl;
                obj_data[wr_idx] <= next_data;
            end
        end
    end

    // Read data and transmit frame fields
    always_comb begin
        if (address == cmoh_pkg::OFF_CMD_MASK) readdata = cmd_mask;
        else if (address == cmoh_pkg::OFF_CMD_REQ) readdata = {27'h0, cmd_obj + 5'h01};
        else if (address == cmoh_pkg::OFF_MASK) readdata = if_msk;
        else if (address == cmoh_pkg::OFF_ARB) readdata = if_arb;
        else if (address == cmoh_pkg::OFF_CTL) readdata = if_ctl;
        else if (address == cmoh_pkg::OFF_DATA_LO) readdata = if_data[31:0];
        else if (address == cmoh_pkg::OFF_DATA_HI) readdata = if_data[63:32];
        else if (address == cmoh_pkg::OFF_INT_ID) readdata = {27'h0, int_id};
        else if (address == cmoh_pkg::OFF_STATUS) readdata = {30'h0, rx_pend, tx_busy};
        else readdata = cmoh_pkg::BAD_ADDR_DATA;
    end

    assign tx_start = tx_start_q;
    assign tx_id = obj_arb[tx_obj][28:0];
    assign tx_xtd = obj_arb[tx_obj][cmoh_pkg::ARB_XTD];
    assign tx_remote = !obj_arb[tx_obj][cmoh_pkg::ARB_DIR];
    assign tx_dlc = obj_ctl[tx_obj][3:0];
    assign tx_payload = obj_data[tx_obj];
    assign interrupt_identification_register = int_id;
endmodule : cmoh_top
`default_nettype wire

// ==== verilog/cmoh_pkg.sv ====
// Package of the object handler: register offsets, field layouts, reset values, states.
// Assumes a single clock domain; consumed by cmoh_top and cmoh_scan.
package cmoh_pkg;
    localparam int NUM_OBJ = 32;
    localparam int OBJ_W = 5;
    localparam int ADDR_W = 6;
    // Register byte offsets
    localparam logic [5:0] OFF_CMD_MASK = 6'h00;
    localparam logic [5:0] OFF_CMD_REQ = 6'h04;
    localparam logic [5:0] OFF_MASK = 6'h08;
    localparam logic [5:0] OFF_ARB = 6'h0c;
    localparam logic [5:0] OFF_CTL = 6'h10;
    localparam logic [5:0] OFF_DATA_LO = 6'h14;
    localparam logic [5:0] OFF_DATA_HI = 6'h18;
    localparam logic [5:0] OFF_INT_ID = 6'h1c;
    localparam logic [5:0] OFF_STATUS = 6'h20;
    // Command mask bits
    localparam int CM_WRITE_NOT_READ = 7;
    localparam int CM_MASK = 6;
    localparam int CM_ARB = 5;
    localparam int CM_CONTROL = 4;
    localparam int CM_CLR_INT = 3;
    localparam int CM_TXRQ_NEW_DATA_FLAG = 2;
    localparam int CM_PAYLOAD_LOW = 1;
    localparam int CM_PAYLOAD_HIGH = 0;
    // Arbitration word: [31] valid, [30] extended, [29] direction, [28:0] id
    localparam int ARB_VALID = 31;
    localparam int ARB_XTD = 30;
    localparam int ARB_DIR = 29;
    // Mask word: [31] mask extended, [30] mask direction, [28:0] id mask
    localparam int MSK_XTD = 31;
    localparam int MSK_DIR = 30;
    // Control word fields
    localparam int CTL_NEW_DATA_FLAG = 15;
    localparam int CTL_MESSAGE_LOST_FLAG = 14;
    localparam int CTL_INTERRUPT_PENDING = 13;
    localparam int CTL_USE_ACCEPTANCE_MASK = 12;
    localparam int CTL_TXIE = 11;
    localparam int CTL_RECEIVE_INTERRUPT_ENABLE = 10;
    localparam int CTL_REMOTE_ENABLE = 9;
    localparam int CTL_TRANSMIT_REQUEST = 8;
    localparam int CTL_EOB = 7;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] INT_ID_NONE = 32'h0000_0000;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_beef;
    typedef enum logic [2:0] {
        CMOH_IDLE = 3'b000,
        CMOH_XFER = 3'b001,
        CMOH_RX_SCAN = 3'b010,
        CMOH_RX_STORE = 3'b011,
        CMOH_TX_LOAD = 3'b100,
        CMOH_TX_DONE = 3'b101
    } cmoh_state_t;
endpackage : cmoh_pkg

// ==== verilog/cmoh_scan.sv ====
// Combinational acceptance scan over all objects, lowest number wins.
// Assumes flattened object fields supplied by cmoh_top; returns a hit and its index.
`timescale 1ns/10ps
`default_nettype none
module cmoh_scan #(
    parameter int N = 32
) (
    // Object fields
    input wire logic [N*32-1:0] arb_flat,
    input wire logic [N*32-1:0] msk_flat,
    input wire logic [N-1:0] use_acceptance_mask,
    // Incoming frame
    input wire logic [28:0] rx_id,
    input wire logic rx_xtd,
    input wire logic rx_remote,
    // Result
    output logic hit,
    output logic [4:0] hit_idx
);
    logic [N-1:0] match;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            logic [31:0] a;
            logic [31:0] m;
            logic [28:0] idm;
            logic xm;
            logic dm;
            assign a = arb_flat[g*32 +: 32];
            assign m = msk_flat[g*32 +: 32];
            assign idm = use_acceptance_mask[g] ? m[28:0] : {29{1'b1}};
            assign xm = use_acceptance_mask[g] ? m[cmoh_pkg::MSK_XTD] : 1'b1;
            assign dm = use_acceptance_mask[g] ? m[cmoh_pkg::MSK_DIR] : 1'b1;
            // Unless a used mask clears MSK_DIR, remote frames hit transmit objects and data frames hit receive objects
            assign match[g] = a[cmoh_pkg::ARB_VALID] && (((a[28:0] ^ rx_id) & idm) == 29'h0)
                && (!xm || (a[cmoh_pkg::ARB_XTD] == rx_xtd))
                && (!dm || (a[cmoh_pkg::ARB_DIR] == rx_remote));
        end
    endgenerate

    always_comb begin
        hit = 1'b0;
        hit_idx = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit = 1'b1;
                hit_idx = 5'(i);
            end
        end
    end
endmodule : cmoh_scan
`default_nettype wire

// ==== tb/cmoh_props.sv ====
// Checker of bus and transmit port timing of cmoh_top.
// Assumes one clock; bound to every cmoh_top below.
`timescale 1ns/10ps
`default_nettype none
module cmoh_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Engine
    input wire logic tx_ready,
    input wire logic tx_ok,
    input wire logic tx_start,
    input wire logic [28:0] tx_id
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic busy, next_busy;
    always_comb next_busy = rst_b & (tx_start | (busy & !tx_ok));
    always_ff @(posedge clk) busy <= next_busy;
    tx_pulse_a: assert property (tx_start |=> !tx_start) else $error("start too long");
    tx_ready_a: assert property (tx_start |-> $past(tx_ready)) else $error("start without ready");
    one_frame_a: assert property (busy |-> !tx_start) else $error("second start in flight");
    id_hold_a: assert property (busy |-> $stable(tx_id)) else $error("id moved in flight");
    wait_idle_a: assert property (waitrequest |-> read || write) else $error("stall without request");
    wait_bound_a: assert property ((read || write) |-> ##[0:48] !waitrequest) else $error("stall too long");
    xfer_stall_a: assert property (write && !waitrequest && address == cmoh_pkg::OFF_CMD_REQ |=>
        (read || write) |-> waitrequest) else $error("no stall in transfer");
    bad_addr_a: assert property (read && address > cmoh_pkg::OFF_STATUS && !waitrequest |->
        readdata == cmoh_pkg::BAD_ADDR_DATA) else $error("bad unmapped data");
    cover property (tx_start);
    cover property (busy && write && !waitrequest);
    cover property (read && !waitrequest && address > cmoh_pkg::OFF_STATUS);
endmodule : cmoh_props
bind cmoh_top cmoh_props u_props (.clk, .rst_b, .address, .read, .write, .readdata, .waitrequest, .tx_ready,
    .tx_ok, .tx_start, .tx_id);
`default_nettype wire

// ==== tb/cmoh_engine.sv ====
// Model of the protocol engine: hands frames in, takes transmissions and logs them.
// Assumes the bench calls send_frame and reads the logs by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module cmoh_engine (
    // Clock
    input wire logic clk,
    // Receive side
    output logic rx_header_valid,
    output logic [28:0] rx_id,
    output logic rx_xtd,
    output logic rx_remote,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_payload,
    // Transmit side
    input wire logic tx_start,
    input wire logic [28:0] tx_id,
    input wire logic [63:0] tx_payload,
    output logic tx_ready,
    output logic tx_ok
);
    logic hold = 1'h1;
    int n_sent = 0;
    logic [28:0] sent_id [8];
    logic [63:0] sent_pay [8];
    initial begin
        {rx_header_valid, rx_id, rx_xtd, rx_remote, rx_dlc, rx_payload, tx_ok, tx_ready} = '0;
        forever begin
            @(posedge clk);
            tx_ready <= !hold && !tx_start;
            if (tx_start) begin
                sent_id[n_sent] = tx_id;
                sent_pay[n_sent] = tx_payload;
                n_sent++;
                repeat (30) @(posedge clk);
                tx_ok <= 1'h1;
                @(posedge clk);
                tx_ok <= 1'h0;
            end
        end
    end
    task automatic send_frame(input logic [28:0] id, input logic rem, input logic [3:0] dlc, input logic [63:0] pay);
        @(posedge clk);
        rx_header_valid <= 1'h1;
        {rx_id, rx_remote, rx_dlc, rx_payload} <= {id, rem, dlc, pay};
        @(posedge clk);
        rx_header_valid <= 1'h0;
        {rx_id, rx_remote, rx_dlc, rx_payload} <= ~{id, rem, dlc, pay};
        repeat (4) @(posedge clk);
    endtask : send_frame
endmodule : cmoh_engine
`default_nettype wire

// ==== tb/cmoh_top_tb.sv ====
// Self-checking bench of cmoh_top with the engine model on the far side.
// Assumes a 100 MHz clock and the engine's logs reached by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module cmoh_top_tb;
    logic clk, rst_b, read, write, waitrequest, rx_header_valid, rx_xtd, rx_remote, tx_ready, tx_ok, tx_start, tx_xtd;
    logic [5:0] address;
    logic [31:0] writedata, readdata, q, arb_q, ctl_q;
    logic [28:0] rx_id, tx_id;
    logic [3:0] rx_dlc, tx_dlc;
    logic [63:0] rx_payload, tx_payload;
    logic [4:0] interrupt_identification_register;
    int err_count = 0;
    int num_checks = 0;
    typedef struct packed {logic [4:0] n; logic [31:0] msk, arb; logic [15:0] ctl; logic [63:0] pay;} cmoh_cfg_t;
    typedef struct packed {logic [28:0] id; logic rem; logic [3:0] dlc; logic [63:0] pay; logic [1:0] cnt;
        logic [4:0] obj; logic [15:0] ectl; logic [31:0] elo;} cmoh_row_t;
    cmoh_cfg_t cfg [6] = '{'{5'h1, 32'hdfff_fff0, 32'h8000_0100, 16'h1480, 64'h0},
        '{5'h2, 32'h0, 32'h8000_0105, 16'h0080, 64'h0}, '{5'h3, 32'h0, 32'ha000_0200, 16'h0288, {2{32'h3333_3333}}},
        '{5'h4, 32'h0, 32'ha000_0300, 16'h0088, 64'h0}, '{5'h5, 32'h9fff_ffff, 32'ha000_0400, 16'h1188,
        {2{32'h5555_5555}}}, '{5'h6, 32'h0, 32'ha000_0001, 16'h0088, 64'h0}};
    cmoh_row_t rows [5] = '{'{29'h105, 1'h0, 4'h8, 64'h0706_0504_0302_0100, 2'h1, 5'h1, 16'h8008, 32'h0302_0100},
        '{29'h10a, 1'h0, 4'h2, 64'h1111_2222_3333_4444, 2'h2, 5'h1, 16'hc002, 32'h3333_4444},
        '{29'h200, 1'h1, 4'h0, 64'h0, 2'h1, 5'h3, 16'h0108, 32'h3333_3333},
        '{29'h300, 1'h1, 4'h0, 64'h0, 2'h1, 5'h4, 16'h0008, 32'h0},
        '{29'h400, 1'h1, 4'h3, 64'h0, 2'h1, 5'h5, 16'h8003, 32'h5555_5555}};
    cmoh_top dut (.clk, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest, .rx_header_valid,
        .rx_id, .rx_xtd, .rx_remote, .rx_dlc, .rx_payload, .tx_ready, .tx_ok, .tx_start, .tx_id, .tx_xtd,
        .tx_remote(), .tx_dlc, .tx_payload, .interrupt_identification_register);
    cmoh_engine eng (.clk, .rx_header_valid, .rx_id, .rx_xtd, .rx_remote, .rx_dlc, .rx_payload, .tx_start,
        .tx_id, .tx_payload, .tx_ready, .tx_ok);
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        @(posedge clk);
        while (waitrequest !== 1'h0) begin
            n++;
            if (n > 100) begin
                err_count++;
                print_verdict();
            end
            @(posedge clk);
        end
        q = readdata;
        write <= 1'h0;
        read <= 1'h0;
        @(posedge clk);
    endtask : bus
    task automatic obj(input logic [4:0] n, input logic [31:0] msk, arb, ctl, input logic [63:0] pay, input logic [7:0] cm);
        bus(1'h1, cmoh_pkg::OFF_CMD_MASK, {24'h0, cm});
        bus(1'h1, cmoh_pkg::OFF_MASK, msk);
        bus(1'h1, cmoh_pkg::OFF_ARB, arb);
        bus(1'h1, cmoh_pkg::OFF_CTL, ctl);
        bus(1'h1, cmoh_pkg::OFF_DATA_LO, pay[31:0]);
        bus(1'h1, cmoh_pkg::OFF_DATA_HI, pay[63:32]);
        bus(1'h1, cmoh_pkg::OFF_CMD_REQ, {27'h0, n});
    endtask : obj
    task automatic rdobj(input logic [4:0] n);
        bus(1'h1, cmoh_pkg::OFF_CMD_MASK, 32'h0000_007f);
        bus(1'h1, cmoh_pkg::OFF_CMD_REQ, {27'h0, n});
        bus(1'h0, cmoh_pkg::OFF_ARB, 32'h0);
        arb_q = q;
        bus(1'h0, cmoh_pkg::OFF_CTL, 32'h0);
        ctl_q = q;
        bus(1'h0, cmoh_pkg::OFF_DATA_LO, 32'h0);
    endtask : rdobj
    task automatic wait_sent(input int k);
        int n;
        n = 0;
        while (eng.n_sent < k) begin
            n++;
            if (n > 2000) begin
                err_count++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask : wait_sent
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_b, address, read, write, writedata} = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        bus(1'h0, cmoh_pkg::OFF_ARB, 32'h0);
        chk("arb reset", cmoh_pkg::RESET_WORD, q);
        chk("int id reset", 64'h0, interrupt_identification_register);
        bus(1'h0, 6'h24, 32'h0);
        chk("unmapped read", cmoh_pkg::BAD_ADDR_DATA, q);
        foreach (cfg[i]) obj(cfg[i].n, cfg[i].msk, cfg[i].arb, {16'h0, cfg[i].ctl}, cfg[i].pay, 8'hf3);
        foreach (rows[i]) begin
            repeat (rows[i].cnt) eng.send_frame(rows[i].id, rows[i].rem, rows[i].dlc, rows[i].pay);
            chk("int id", {63'h0, rows[i].obj == 5'h1}, interrupt_identification_register);
            rdobj(rows[i].obj);
            chk("stored low word", rows[i].elo, q);
            chk("stored id", rows[i].id, arb_q[28:0]);
            chk("stored flags", rows[i].ectl, ctl_q[15:0] & 16'hc10f);
        end
        obj(5'h6, 32'h0, 32'h0, 32'h0, {2{32'h6666_6666}}, 8'h87);
        eng.hold <= 1'h0;
        wait_sent(2);
        obj(5'h6, 32'h0, 32'h0, 32'h0, {2{32'h7777_7777}}, 8'h87);
        wait_sent(3);
        repeat (60) @(posedge clk);
        chk("sent count", 3, eng.n_sent);
        chk("first id", 29'h200, eng.sent_id[0]);
        chk("first payload", {2{32'h3333_3333}}, eng.sent_pay[0]);
        chk("second id", 29'h001, eng.sent_id[1]);
        chk("second payload", {2{32'h6666_6666}}, eng.sent_pay[1]);
        chk("resent payload", {2{32'h7777_7777}}, eng.sent_pay[2]);
        rdobj(5'h6);
        chk("flags after send", 16'h0008, ctl_q[15:0] & 16'hc10f);
        obj(5'h5, 32'h0, 32'h0, 32'h0, {2{32'h9999_9999}}, 8'h87);
        wait_sent(4);
        chk("answer header", {4'h3, 2'h0, 29'h400}, {tx_dlc, tx_xtd, dut.tx_remote, eng.sent_id[3]});
        chk("answer payload", {2{32'h9999_9999}}, eng.sent_pay[3]);
        print_verdict();
    end
endmodule : cmoh_top_tb
`default_nettype wire
